// ===== fliq_checker.sv
/* port checker for fliq_ctrl: bus answer, vector hold, blocking.
   assumes a bind from the bench top onto every fliq_ctrl. */
`default_nettype none
module fliq_checker (
  // clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core side
  input wire logic        i_instr_last,
  input wire logic        i_instr_return_from_irq_instr,
  input wire logic        i_vector_ack,
  input wire logic        i_power_down,
  input wire logic        o_vector_req,
  input wire logic [15:0] o_vector_addr,
  input wire logic [3:0]  o_vector_src,
  input wire logic        o_wake_req
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // read access phase, prdata must be settled here
  wire rd = psel && penable && !pwrite;
  // write to the primary enable register
  wire ie_wr = psel && penable && pwrite && (paddr == 8'ha8);

  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; psel && penable |-> !pslverr; endproperty
  a_err: assert property (p_err) else $error("pslverr high");
  property p_hold;
    o_vector_req && !i_vector_ack |=> o_vector_req && $stable(o_vector_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("vector dropped");
  property p_vec;
    o_vector_req |-> o_vector_addr == ((o_vector_src == 4'hf) ? 16'h0083 :
      16'h0003 + {9'h000, o_vector_src, 3'h0});
  endproperty
  a_vec: assert property (p_vec) else $error("vector address");
  property p_last; $rose(o_vector_req) |-> $past(i_instr_last); endproperty
  a_last: assert property (p_last) else $error("call mid instr");
  property p_return_from_irq_instr; $rose(o_vector_req) |-> !$past(i_instr_return_from_irq_instr); endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("call after return_from_irq_instr");
  property p_iew; $rose(o_vector_req) |-> !$past(ie_wr); endproperty
  a_iew: assert property (p_iew) else $error("call after write");
  property p_rsv; rd && paddr == 8'ha8 |-> !prdata[6]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_umap; rd && paddr == 8'h00 |-> prdata == 32'h0; endproperty
  a_umap: assert property (p_umap) else $error("unmapped read");
  property p_wake; !i_power_down |-> !o_wake_req; endproperty
  a_wake: assert property (p_wake) else $error("wake while run");
  c_req: cover property ($rose(o_vector_req));
  c_ack: cover property (o_vector_req && i_vector_ack);
  c_wake: cover property (o_wake_req);
endmodule // fliq_checker
`default_nettype wire

// ===== fliq_core_model.sv
/* core sequencer model: last-cycle marks, vector ack, return pulse.
   assumes one clock with the controller; slow mode stretches both. */
`default_nettype none
module fliq_core_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control and request
  input  wire logic i_slow,
  input  wire logic i_req,
  // sequencer outputs
  output var  logic o_last,
  output var  logic o_return_from_irq_instr,
  output var  logic o_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] svc_q;  // cycles left in the service routine
  logic [1:0] cnt_q;  // instruction phase counter
  // one process: slow mode gives four-cycle instructions, late acks
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      svc_q <= 4'h0;
      cnt_q <= 2'h0;
      o_last <= 1'b0;
      o_return_from_irq_instr <= 1'b0;
      o_ack <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      o_last <= !i_slow || (cnt_q == 2'h3);
      // one-cycle ack, never twice for one request
      o_ack <= i_req && !o_ack && (!i_slow || cnt_q[0]);
      o_return_from_irq_instr <= (svc_q == 4'h1);
      if (o_ack)
        svc_q <= 4'h6;
      else if (svc_q != 4'h0)
        svc_q <= svc_q - 4'h1;
    end
  end
endmodule // fliq_core_model
`default_nettype wire

// ===== fliq_ctrl.v
/*
 * four-level interrupt controller: enables, priorities, external
 * trigger logic, arbitration and vector request toward the core.
 * assumes an apb master on i_core_clk, a core sequencer that reports
 * last-cycle / return / grant, and peripheral flags at core clock.
 */
`include "fliq_defines.vh"
`default_nettype none

module fliq_ctrl
(
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // external pins, asynchronous, active low by default polarity
  input  wire [3:0]  i_ext_irq_pin,
  input  wire [1:0]  i_alt_irq_pin,
  input  wire [1:0]  i_alt_route_sel,
  input  wire        i_power_down,
  // peripheral request flags, same clock, index 0 = source 0
  input  wire [15:0] i_periph_flag,
  // core sequencer
  input  wire        i_instr_last,
  input  wire        i_instr_return_from_irq_instr,
  input  wire        i_vector_ack,
  // vector request
  output wire        o_vector_req,
  output reg  [15:0] o_vector_addr,
  output reg  [3:0]  o_vector_src,
  output reg  [15:0] o_ext_flag_state,
  output wire        o_wake_req
);

  // registers
  reg  [7:0]  timer_control_and_ext_irq_flags_q;        // timer control plus ext0/1 flags
  reg  [7:0]  ie_q;          // primary enable
  reg  [7:0]  eie_a_q;       // extended enable a
  reg  [7:0]  eie_b_q;       // extended enable b
  reg  [7:0]  xctl_q;        // external 2/3 control
  reg  [7:0]  aux_q;         // ext0/1 polarity
  reg  [7:0]  pl0_q;         // priority low 0
  reg  [7:0]  ph0_q;         // priority high 0
  reg  [7:0]  pl1_q;         // priority low 1
  reg  [7:0]  ph1_q;         // priority high 1
  reg  [7:0]  pl2_q;         // priority low 2
  reg  [7:0]  ph2_q;         // priority high 2
  reg  [15:0] flag_samp_q;   // sampled request flags
  reg  [3:0]  pin_s1_q;      // synchroniser first stage
  reg  [3:0]  pin_s2_q;      // synchroniser second stage
  reg  [3:0]  pin_d_q;       // delayed level for edge detect
  reg  [3:0]  active_q;      // in-service per level, bit3 = level1
  reg         hold_q;        // one-instruction block
  reg         req_q;         // vector request pending to core
  reg  [1:0]  req_lvl_q;     // level of pending request

  // apb strobes: zero wait state
  wire wr_en = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // external pin sources; 2/3 may be taken from serial pins
  wire [3:0] pin_raw = {
    i_alt_route_sel[1] ? i_alt_irq_pin[1] : i_ext_irq_pin[3],
    i_alt_route_sel[0] ? i_alt_irq_pin[0] : i_ext_irq_pin[2],
    i_ext_irq_pin[1:0]};

  // two-flop synchroniser; only stage two feeds logic
  always @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      // idle pin level is high, so no false edge or level after reset
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
      pin_d_q  <= 4'hf;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_d_q  <= pin_s2_q;
    end
  end

  // per-input polarity and type
  wire [3:0] pol = {xctl_q[`FLIQ_XC_IRQ3_POL], xctl_q[`FLIQ_XC_IRQ2_POL],
                    aux_q[`FLIQ_AUX_IRQ1_POL], aux_q[`FLIQ_AUX_IRQ0_POL]};
  wire [3:0] typ = {xctl_q[`FLIQ_XC_IRQ3_TYPE], xctl_q[`FLIQ_XC_IRQ2_TYPE],
                    timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ1_TYPE], timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ0_TYPE]};
  // power-down forces edge configs to level sensing
  wire [3:0] edge_mode = typ & {4{~i_power_down}};
  // polarity inverts so active reads as one
  wire [3:0] lvl_now = pin_s2_q ^ ~pol;
  wire [3:0] lvl_old = pin_d_q ^ ~pol;
  // edge: inactive to active; level: active now
  wire [3:0] ext_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_trig
      assign ext_hit[gi] = edge_mode[gi] ? (lvl_now[gi] & ~lvl_old[gi])
                                         : lvl_now[gi];
    end
  endgenerate

  // individual enables in polling order
  wire [15:0] en_vec = {
    eie_b_q[0], eie_a_q[6:0],
    xctl_q[`FLIQ_XC_IRQ3_EN], xctl_q[`FLIQ_XC_IRQ2_EN],
    ie_q[5:0]};

  // live request flags: external from registers, others from peripherals
  wire [15:0] live_flag = {
    i_periph_flag[15:8],
    xctl_q[`FLIQ_XC_IRQ3_FLAG], xctl_q[`FLIQ_XC_IRQ2_FLAG],
    i_periph_flag[5:3],
    timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ1_FLAG],
    i_periph_flag[1],
    timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ0_FLAG]};

  // priority high/low vectors in source order
  wire [15:0] pr_h = {ph2_q[0], ph1_q[6:0], ph0_q};
  wire [15:0] pr_l = {pl2_q[0], pl1_q[6:0], pl0_q};

  // request gating
  wire [15:0] active_req = flag_samp_q & en_vec &
                           {16{ie_q[`FLIQ_IE_GLOBAL_BIT]}};

  // arbitration: highest level, lowest index within it
  reg  [3:0]  win_src;
  reg  [1:0]  win_lvl;
  reg         win_any;
  integer     k;
  always @*
  begin
    win_src = 4'h0;
    win_lvl = 2'b00;
    win_any = 1'b0;
    // scan from last so earliest index wins ties
    for (k = 15; k >= 0; k = k - 1)
    begin
      if (active_req[k])
      begin
        // pair 11 = level1 highest, 00 = level4
        if (!win_any || {pr_h[k], pr_l[k]} >= win_lvl)
        begin
          win_src = k[3:0];
          win_lvl = {pr_h[k], pr_l[k]};
          win_any = 1'b1;
        end
      end
    end
  end

  // winning request level, one bit per level
  wire [3:0] lvl_onehot = 4'b0001 << win_lvl;
  // blocked if any service at equal or higher level
  wire [3:0] ge_mask = ~(lvl_onehot - 4'b0001);
  wire       svc_block = |(active_q & ge_mask);
  // writes to enable/priority regs set the hold
  wire cfg_wr = wr_en && (paddr == `FLIQ_ADDR_IE_REG ||
    paddr == `FLIQ_ADDR_EXT_A || paddr == `FLIQ_ADDR_EXT_B ||
    paddr == `FLIQ_ADDR_PRIO_L0 || paddr == `FLIQ_ADDR_PRIO_H0 ||
    paddr == `FLIQ_ADDR_PRIO_L1 || paddr == `FLIQ_ADDR_PRIO_H1 ||
    paddr == `FLIQ_ADDR_PRIO_L2 || paddr == `FLIQ_ADDR_PRIO_H2);
  wire fire = win_any && !svc_block && i_instr_last && !hold_q &&
              !i_instr_return_from_irq_instr && !cfg_wr && !req_q;
  assign o_vector_req = req_q;
  wire grant = req_q & i_vector_ack;
  // vector clears for edge-activated ext0/1/2/3 flags
  wire [3:0] ext_src = {o_vector_src == 4'd7, o_vector_src == 4'd6,
                        o_vector_src == 4'd2, o_vector_src == 4'd0};
  wire [3:0] hw_clr = {4{grant}} & ext_src & typ;

  // vector address from source index
  function [15:0] vec_of;
    input [3:0] s;
    begin
      if (s == 4'd15)
        vec_of = `FLIQ_VEC_TIMER3;
      else
        vec_of = `FLIQ_VEC_BASE + {9'h000, s, 3'b000};
    end
  endfunction

  // sampling, request and in-service tracking
  always @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flag_samp_q   <= 16'h0000;
      active_q      <= 4'h0;
      hold_q        <= 1'b0;
      req_q         <= 1'b0;
      req_lvl_q     <= 2'b00;
      o_vector_addr <= 16'h0000;
      o_vector_src  <= 4'h0;
    end
    else
    begin
      flag_samp_q <= live_flag;
      // hold lasts until the next instruction completes
      if (i_instr_return_from_irq_instr || cfg_wr)
        hold_q <= 1'b1;
      else if (i_instr_last)
        hold_q <= 1'b0;
      if (fire)
      begin
        req_q         <= 1'b1;
        req_lvl_q     <= win_lvl;
        o_vector_addr <= vec_of(win_src);
        o_vector_src  <= win_src;
      end
      else if (grant)
        req_q <= 1'b0;
      // return pops highest active level; grant pushes new level
      if (grant)
        active_q <= active_q | (4'b0001 << req_lvl_q);
      else if (i_instr_return_from_irq_instr)
      begin
        if (active_q[3])
          active_q[3] <= 1'b0;
        else if (active_q[2])
          active_q[2] <= 1'b0;
        else if (active_q[1])
          active_q[1] <= 1'b0;
        else
          active_q[0] <= 1'b0;
      end
    end
  end

  // register writes; hardware set beats software clear
  always @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      timer_control_and_ext_irq_flags_q  <= `FLIQ_RST_BYTE;
      ie_q    <= `FLIQ_RST_BYTE;
      eie_a_q <= `FLIQ_RST_BYTE;
      eie_b_q <= `FLIQ_RST_BYTE;
      xctl_q  <= `FLIQ_RST_BYTE;
      aux_q   <= `FLIQ_RST_BYTE;
      pl0_q   <= `FLIQ_RST_BYTE;
      ph0_q   <= `FLIQ_RST_BYTE;
      pl1_q   <= `FLIQ_RST_BYTE;
      ph1_q   <= `FLIQ_RST_BYTE;
      pl2_q   <= `FLIQ_RST_BYTE;
      ph2_q   <= `FLIQ_RST_BYTE;
    end
    else
    begin
      if (wr_en)
      begin
        case (paddr)
          `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG: timer_control_and_ext_irq_flags_q <= pwdata[7:0];
          // bit 6 is expected written as zero; stored zero anyway
          `FLIQ_ADDR_IE_REG:  ie_q    <= pwdata[7:0] & 8'hbf;
          `FLIQ_ADDR_EXT_A:   eie_a_q <= pwdata[7:0] & 8'h7f;
          `FLIQ_ADDR_EXT_B:   eie_b_q <= pwdata[7:0] & 8'h01;
          `FLIQ_ADDR_XCTL:    xctl_q  <= pwdata[7:0];
          `FLIQ_ADDR_AUX:     aux_q   <= pwdata[7:0] & 8'h03;
          `FLIQ_ADDR_PRIO_L0: pl0_q   <= pwdata[7:0];
          `FLIQ_ADDR_PRIO_H0: ph0_q   <= pwdata[7:0];
          `FLIQ_ADDR_PRIO_L1: pl1_q   <= pwdata[7:0] & 8'h7f;
          `FLIQ_ADDR_PRIO_H1: ph1_q   <= pwdata[7:0] & 8'h7f;
          `FLIQ_ADDR_PRIO_L2: pl2_q   <= pwdata[7:0] & 8'h01;
          `FLIQ_ADDR_PRIO_H2: ph2_q   <= pwdata[7:0] & 8'h01;
          default:            ;
        endcase
      end
      // vector clears edge flags, hardware set applied last so wins
      if (hw_clr[0])
        timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ0_FLAG] <= 1'b0;
      if (hw_clr[1])
        timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ1_FLAG] <= 1'b0;
      if (hw_clr[2])
        xctl_q[`FLIQ_XC_IRQ2_FLAG] <= 1'b0;
      if (hw_clr[3])
        xctl_q[`FLIQ_XC_IRQ3_FLAG] <= 1'b0;
      if (ext_hit[0])
        timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ0_FLAG] <= 1'b1;
      if (ext_hit[1])
        timer_control_and_ext_irq_flags_q[`FLIQ_TC_IRQ1_FLAG] <= 1'b1;
      if (ext_hit[2])
        xctl_q[`FLIQ_XC_IRQ2_FLAG] <= 1'b1;
      if (ext_hit[3])
        xctl_q[`FLIQ_XC_IRQ3_FLAG] <= 1'b1;
    end
  end

  // enabled, globally gated request snapshot (active_req) for status outputs
  always @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_ext_flag_state <= 16'h0000;
    else
      o_ext_flag_state <= active_req;
  end

  // wake request from enabled external 2/3 events in power-down
  assign o_wake_req = i_power_down &
    ((xctl_q[`FLIQ_XC_IRQ2_FLAG] & xctl_q[`FLIQ_XC_IRQ2_EN]) |
     (xctl_q[`FLIQ_XC_IRQ3_FLAG] & xctl_q[`FLIQ_XC_IRQ3_EN]));

  // read data registered at the setup edge; stands through access
  always @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      case (paddr)
        `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG: prdata <= {24'h000000, timer_control_and_ext_irq_flags_q};
        `FLIQ_ADDR_IE_REG:   prdata <= {24'h000000, ie_q};
        `FLIQ_ADDR_EXT_A:    prdata <= {24'h000000, eie_a_q};
        `FLIQ_ADDR_EXT_B:    prdata <= {24'h000000, eie_b_q};
        `FLIQ_ADDR_XCTL:     prdata <= {24'h000000, xctl_q};
        `FLIQ_ADDR_AUX:      prdata <= {24'h000000, aux_q};
        `FLIQ_ADDR_PRIO_L0:  prdata <= {24'h000000, pl0_q};
        `FLIQ_ADDR_PRIO_H0:  prdata <= {24'h000000, ph0_q};
        `FLIQ_ADDR_PRIO_L1:  prdata <= {24'h000000, pl1_q};
        `FLIQ_ADDR_PRIO_H1:  prdata <= {24'h000000, ph1_q};
        `FLIQ_ADDR_PRIO_L2:  prdata <= {24'h000000, pl2_q};
        `FLIQ_ADDR_PRIO_H2:  prdata <= {24'h000000, ph2_q};
        `FLIQ_ADDR_FLAGS:    prdata <= {16'h0000, flag_samp_q};
        `FLIQ_ADDR_STATUS:   prdata <= {20'h00000, active_q, hold_q,
                                        req_q, req_lvl_q, o_vector_src};
        default:             prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // fliq_ctrl

`default_nettype wire

// ===== fliq_ctrl_test.sv
/* self-checking bench for fliq_ctrl: registers over apb, arbitration,
   external trigger and wake. assumes fliq_core_model as the core. */
`include "fliq_defines.vh"
`default_nettype none
module fliq_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0;          // clock, async reset
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pins = 4'hf;                 // idle high, active low
  logic [15:0] fl = 16'h0000;               // peripheral flags
  logic        pd = 0, slow = 0, rs = 0, r;
  logic [7:0]  lf = 8'h62, q;               // lfsr seed 98
  logic [15:0] a;
  wire         pready, pslverr, vreq, wake, last, return_from_irq_instr, ack;
  wire  [31:0] prdata;
  wire  [15:0] vaddr, est;
  wire  [3:0]  vsrc;
  int          errors = 0, checks = 0, cyc = 0;

  fliq_ctrl i_fliq_ctrl (.i_core_clk(clk), .i_reset_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .i_ext_irq_pin(pins), .i_alt_irq_pin(2'h3),
    .i_alt_route_sel(2'h0), .i_power_down(pd), .i_periph_flag(fl),
    .i_instr_last(last), .i_instr_return_from_irq_instr(return_from_irq_instr), .i_vector_ack(ack),
    .o_vector_req(vreq), .o_vector_addr(vaddr), .o_vector_src(vsrc),
    .o_ext_flag_state(est), .o_wake_req(wake));
  fliq_core_model i_fliq_core_model (.i_clk(clk), .i_rst_n(rst_n),
    .i_slow(slow), .i_req(vreq), .o_last(last), .o_return_from_irq_instr(return_from_irq_instr),
    .o_ack(ack));

  initial forever #50 clk = ~clk;
  // cycle ceiling against hangs; also notes return pulses
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ack === 1'b1 && vreq === 1'b1)
      rs <= 1'b0;
    else if (return_from_irq_instr === 1'b1)
      rs <= 1'b1;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop;
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one apb transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] ad, d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] ad, e);
    apb(0, ad, 8'h00);
    check(nm, q, e);
  endtask
  // vector taken at the ack edge; served flag drops there
  task automatic wait_vec;
    do @(negedge clk); while (!(vreq === 1'b1 && ack === 1'b1));
    a = vaddr;
    r = rs;
    @(posedge clk);
    fl[(a - 16'h3) >> 3] <= 1'b0;
  endtask
  task automatic run_pair(input logic [7:0] p, input logic [15:0] f, s);
    apb(1, `FLIQ_ADDR_PRIO_H0, p);
    fl <= 16'h000a;
    apb(1, `FLIQ_ADDR_IE_REG, 8'h8a);
    wait_vec;
    check("first vector", a, f);
    wait_vec;
    check("second vector", a, s);
    check("return first", r, 1'b1);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h00);
    repeat (10) @(posedge clk);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rchk("enable reset", `FLIQ_ADDR_IE_REG, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      lf = lfsr(lf);
      apb(1, `FLIQ_ADDR_IE_REG, lf);
      rchk("enable", `FLIQ_ADDR_IE_REG, lf & 8'hbf);
      apb(1, `FLIQ_ADDR_EXT_A, lf);
      rchk("ext enable", `FLIQ_ADDR_EXT_A, lf & 8'h7f);
      apb(1, `FLIQ_ADDR_PRIO_L1, lf);
      rchk("prio low1", `FLIQ_ADDR_PRIO_L1, lf & 8'h7f);
    end
    apb(1, `FLIQ_ADDR_IE_REG, 8'h00);
    apb(1, `FLIQ_ADDR_EXT_A, 8'h00);
    apb(1, `FLIQ_ADDR_PRIO_L1, 8'h00);
    run_pair(8'h00, 16'h000b, 16'h001b);
    slow <= 1;
    run_pair(8'h08, 16'h001b, 16'h000b);
    slow <= 0;
    apb(1, `FLIQ_ADDR_PRIO_H0, 8'h00);
    // falling edge on ext0, flag cleared by the call
    apb(1, `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG, 8'h01);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h81);
    pins[0] <= 1'b0;
    wait_vec;
    check("ext0 vector", a, `FLIQ_VEC_BASE);
    repeat (10) @(posedge clk);
    rchk("ext0 edge flag", `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG, 8'h01);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h00);
    apb(1, `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG, 8'h00);
    repeat (5) @(posedge clk);
    rchk("ext0 level flag", `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG, 8'h02);
    pins[0] <= 1'b1;
    // software-set ext1 flag, masked then unmasked globally
    apb(1, `FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG, 8'h0c);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h04);
    repeat (10) @(negedge clk);
    check("masked", vreq, 1'b0);
    check("masked state", est, 16'h0000);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h84);
    wait_vec;
    check("ext1 vector", a, `FLIQ_VEC_BASE + 16'h10);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h00);
    // ext2 edge mode forced to level in power-down
    apb(1, `FLIQ_ADDR_XCTL, 8'h05);
    pd <= 1;
    pins[2] <= 1'b0;
    repeat (6) @(negedge clk);
    check("wake", wake, 1'b1);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h80);
    repeat (4) @(negedge clk);
    check("gated state", est, 16'h0040);
    apb(1, `FLIQ_ADDR_IE_REG, 8'h00);
    pd <= 0;
    pins[2] <= 1'b1;
    repeat (3) @(posedge clk);
    report_and_stop;
  end
endmodule // fliq_ctrl_test

bind fliq_ctrl fliq_checker i_fliq_checker (.i_core_clk(i_core_clk),
  .i_reset_n(i_reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .i_instr_last(i_instr_last),
  .i_instr_return_from_irq_instr(i_instr_return_from_irq_instr), .i_vector_ack(i_vector_ack),
  .i_power_down(i_power_down), .o_vector_req(o_vector_req),
  .o_vector_addr(o_vector_addr), .o_vector_src(o_vector_src),
  .o_wake_req(o_wake_req));
`default_nettype wire

// ===== fliq_defines.vh
/*
 * register offsets, field positions, reset values and vector constants
 * for the four-level interrupt controller.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef FLIQ_DEFINES_VH
`define FLIQ_DEFINES_VH

// apb byte addresses (printed offsets are multiples of four)
`define FLIQ_ADDR_TIMER_CONTROL_AND_EXT_IRQ_FLAGS_REG     8'h88
`define FLIQ_ADDR_IE_REG       8'ha8
// own choices for unprinted registers
`define FLIQ_ADDR_EXT_A        8'hac
`define FLIQ_ADDR_EXT_B        8'hb0
`define FLIQ_ADDR_XCTL         8'hc0
`define FLIQ_ADDR_PRIO_L0      8'hb8
`define FLIQ_ADDR_PRIO_H0      8'hb4
`define FLIQ_ADDR_PRIO_L1      8'hbc
`define FLIQ_ADDR_PRIO_H1      8'hc4
`define FLIQ_ADDR_PRIO_L2      8'hc8
`define FLIQ_ADDR_PRIO_H2      8'hcc
`define FLIQ_ADDR_AUX          8'hd0
`define FLIQ_ADDR_FLAGS        8'hd4
`define FLIQ_ADDR_STATUS       8'hd8

// reset values
`define FLIQ_RST_BYTE          8'h00

// primary enable fields
`define FLIQ_IE_GLOBAL_BIT     7
`define FLIQ_IE_RSVD_BIT       6
// timer control fields
`define FLIQ_TC_IRQ1_FLAG      3
`define FLIQ_TC_IRQ1_TYPE      2
`define FLIQ_TC_IRQ0_FLAG      1
`define FLIQ_TC_IRQ0_TYPE      0
// external control fields
`define FLIQ_XC_IRQ3_POL       7
`define FLIQ_XC_IRQ3_EN        6
`define FLIQ_XC_IRQ3_FLAG      5
`define FLIQ_XC_IRQ3_TYPE      4
`define FLIQ_XC_IRQ2_POL       3
`define FLIQ_XC_IRQ2_EN        2
`define FLIQ_XC_IRQ2_FLAG      1
`define FLIQ_XC_IRQ2_TYPE      0
// auxiliary polarity fields
`define FLIQ_AUX_IRQ1_POL      1
`define FLIQ_AUX_IRQ0_POL      0

// vector table: base and spacing, timer3 skips one slot
`define FLIQ_VEC_BASE          16'h0003
`define FLIQ_VEC_STEP          16'h0008
`define FLIQ_VEC_TIMER3        16'h0083

`endif
